/* bench/fser_regs_properties.sv */
// Checker of handshake, launch and interrupt timing at the flash status block ports
`timescale 1ns/1ns
module fser_chk (
    input wire logic clk,            // Clock
    input wire logic rst_n,          // Sync reset, active low
    input wire logic s_awvalid,      // Write address valid
    input wire logic s_awready,      // Write address ready
    input wire logic s_wvalid,       // Write data valid
    input wire logic s_wready,       // Write data ready
    input wire logic s_bvalid,       // Write response valid
    input wire logic s_bready,       // Write response ready
    input wire logic s_arvalid,      // Read address valid
    input wire logic s_arready,      // Read address ready
    input wire logic s_rvalid,       // Read data valid
    input wire logic s_rready,       // Read data ready
    input wire logic cmd_complete,   // Command finished
    input wire logic seq_violation,  // Sequence violation
    input wire logic prot_violation, // Protection violation
    input wire logic double_fault,   // Double fault
    input wire logic single_fault,   // Single fault
    input wire logic cmd_launch,     // Launch pulse
    input wire logic seq_allow,      // Sequence permission
    input wire logic irq             // Interrupt
);
    logic busy_reg;
    logic busy_next;
    logic cause;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Anything that may move the interrupt level
    assign cause = cmd_complete | seq_violation | prot_violation | double_fault
                 | single_fault | s_bvalid;
    // Tracks a launched command until the controller ends it
    always_comb begin
        busy_next = busy_reg;
        if (cmd_launch) busy_next = 1'b1;
        else if (cmd_complete | seq_violation | prot_violation) busy_next = 1'b0;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) busy_reg <= 1'b0;
        else busy_reg <= busy_next;
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_launch_after_write; cmd_launch |-> $rose(s_bvalid); endproperty
    a_launch_after_write: assert property (p_launch_after_write)
        else $error("launch without a preceding write");
    property p_no_launch_busy; cmd_launch |-> !busy_reg; endproperty
    a_no_launch_busy: assert property (p_no_launch_busy)
        else $error("launch while a command runs");
    property p_viol_blocks; prot_violation |-> ##[1:2] !seq_allow; endproperty
    a_viol_blocks: assert property (p_viol_blocks)
        else $error("sequence still allowed after violation");
    property p_irq_rise;
        $rose(irq) |-> cause || $past(cause, 1) || $past(cause, 2) || $past(cause, 3);
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt rose without cause");
    property p_irq_fall;
        $fell(irq) |-> s_bvalid || $past(s_bvalid, 1) || $past(s_bvalid, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt fell without a write");
    property p_bresp_time;
        s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid;
    endproperty
    a_bresp_time: assert property (p_bresp_time)
        else $error("write response late");
    property p_bhold; s_bvalid && !s_bready |=> s_bvalid; endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response dropped");
    property p_rresp_time; s_arvalid && s_arready |=> s_rvalid; endproperty
    a_rresp_time: assert property (p_rresp_time)
        else $error("read answer late");
    property p_rhold; s_rvalid && !s_rready |=> s_rvalid; endproperty
    a_rhold: assert property (p_rhold)
        else $error("read answer dropped");
endmodule : fser_chk

bind fser_regs fser_chk i_fser_chk (.clk(clk), .rst_n(rst_n), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .cmd_complete(cmd_complete), .seq_violation(seq_violation),
    .prot_violation(prot_violation), .double_fault(double_fault),
    .single_fault(single_fault), .cmd_launch(cmd_launch), .seq_allow(seq_allow), .irq(irq));

/* bench/fser_regs_tb.sv */
// Self-checking bench of the flash status and error interrupt register bank
`timescale 1ns/1ns
module fser_regs_tb;
    import fser_pkg::*;
    logic        clk, rst_n, rdf, launch, allow, ign, irq;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, err_st;
    logic [6:0]  ev;        // 0 done 1 seq 2 prot 3 start 4 df 5 sf 6 status strobe
    int          err_count, samples_checked, launches;

    fser_regs i_fser_regs (.clk(clk), .rst_n(rst_n), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .cmd_complete(ev[0]),
        .seq_violation(ev[1]), .prot_violation(ev[2]), .seq_start(ev[3]),
        .double_fault(ev[4]), .single_fault(ev[5]), .cmd_err_status(err_st),
        .cmd_err_valid(ev[6]), .reset_seq_df(rdf), .cmd_launch(launch), .seq_allow(allow),
        .ignore_single_fault(ign), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and a count of launch pulses
    always #50 clk = ~clk;
    always @(posedge clk) if (launch === 1'b1) launches++;
    // Compare one value and count it
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Let launched updates and the interrupt land
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle
    // Bus write of one register word
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic a, w, b;
        logic [1:0] r;
        int   n;
        n = 0;
        @(posedge clk);
        awaddr <= {22'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            r = bresp;
            n++;
            @(posedge clk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b && n < 40);
        bready <= 1'b0;
        if (!b) chk(32'h0, 32'h1);
        else chk(r, FSER_RESP_OK);
        settle();
    endtask : wr
    // Bus read of one word, judged on response and masked low byte
    task automatic look(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e,
                        input logic [1:0] re = FSER_RESP_OK);
        logic a, v;
        int   n;
        n = 0;
        @(posedge clk);
        araddr <= {22'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            a = arvalid && arready;
            v = rvalid;
            n++;
            if (v) chk({22'h0, rresp, rdata[7:0] & m}, {22'h0, re, e});
            @(posedge clk);
            if (a) arvalid <= 1'b0;
        end while (!v && n < 40);
        rready <= 1'b0;
        if (!v) chk(32'h0, 32'h1);
    endtask : look
    // One-cycle event pulse, then settle
    task automatic pulse(input logic [6:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 7'h0;
        settle();
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        look(FSER_IDX_STATUS, 8'hff, 8'h80);
        look(FSER_IDX_ERRCFG, 8'hff, 8'h00);
        chk(allow, 1'b1);
        wr(FSER_IDX_ERRCFG, 8'hff);
        look(FSER_IDX_ERRCFG, 8'hff, 8'h03);
        look(8'h3f, 8'hff, 8'h00, FSER_RESP_SLV);
    endtask : t_reset
    task automatic t_double();
        pulse(7'h10);
        chk(irq, 1'b1);
        wr(FSER_IDX_ERRSTAT, 8'h00);
        look(FSER_IDX_ERRSTAT, 8'hff, 8'h02);
        wr(FSER_IDX_ERRCFG, 8'h00);
        chk(irq, 1'b0);
        wr(FSER_IDX_ERRSTAT, 8'h02);
        look(FSER_IDX_ERRSTAT, 8'hff, 8'h00);
    endtask : t_double
    task automatic t_single();
        wr(FSER_IDX_CFG, 8'h10);
        chk(ign, 1'b1);
        wr(FSER_IDX_ERRCFG, 8'h01);
        pulse(7'h20);
        look(FSER_IDX_ERRSTAT, 8'hff, 8'h00);
        wr(FSER_IDX_CFG, 8'h00);
        pulse(7'h20);
        chk(irq, 1'b1);
        wr(FSER_IDX_ERRCFG, 8'h00);
        chk(irq, 1'b0);
        wr(FSER_IDX_ERRSTAT, 8'h01);
    endtask : t_single
    task automatic t_launch();
        wr(FSER_IDX_STATUS, 8'h80);
        chk(launches, 1);
        look(FSER_IDX_STATUS, 8'hff, 8'h08);
        wr(FSER_IDX_STATUS, 8'h80);
        chk(launches, 1);
        pulse(7'h41);
        look(FSER_IDX_STATUS, 8'hff, 8'h81);
        wr(FSER_IDX_CFG, 8'h80);
        chk(irq, 1'b1);
        wr(FSER_IDX_CFG, 8'h00);
        chk(irq, 1'b0);
    endtask : t_launch
    task automatic t_errors();
        pulse(7'h02);
        look(FSER_IDX_STATUS, 8'hfc, 8'ha0);
        wr(FSER_IDX_STATUS, 8'h80);
        chk(launches, 1);
        wr(FSER_IDX_STATUS, 8'h0f);
        look(FSER_IDX_STATUS, 8'hff, 8'ha1);
        wr(FSER_IDX_STATUS, 8'h20);
        look(FSER_IDX_STATUS, 8'hfc, 8'h80);
        pulse(7'h04);
        chk(allow, 1'b0);
        look(FSER_IDX_STATUS, 8'hfc, 8'h90);
        wr(FSER_IDX_STATUS, 8'h80);
        chk(launches, 1);
        wr(FSER_IDX_STATUS, 8'h10);
        look(FSER_IDX_STATUS, 8'hfc, 8'h80);
        chk(allow, 1'b1);
    endtask : t_errors
    task automatic t_events();
        wr(FSER_IDX_IRQMASK, 8'h04);
        chk(irq, 1'b1);
        wr(FSER_IDX_IRQSTAT, 8'h1f);
        chk(irq, 1'b0);
        look(FSER_IDX_IRQSTAT, 8'h1f, 8'h00);
        rdf <= 1'b1;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        look(FSER_IDX_STATUS, 8'hff, 8'h83);
    endtask : t_events
    // Verdict and end of run
    task automatic report_and_stop();
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {clk, rst_n, rdf, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr, err_st, ev} = '0;
        {err_count, samples_checked, launches} = '0;
        err_st = 2'h1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_double();
        t_single();
        t_launch();
        t_errors();
        t_events();
        report_and_stop();
    end
    // Watchdog against a hung handshake
    initial begin
        #(3000 * 100);
        err_count++;
        report_and_stop();
    end
endmodule : fser_regs_tb

/* hw/fser_pkg.sv */
// Package of offsets, field positions and reset values for the flash status block
//
// How it works
// - Double fault enable gates double fault interrupt
// - Single fault enable gates single fault interrupt
// - Error configuration bits readable and writable
// - Write one to done flag launches command
// - Sequence violation or illegal command sets access error
// - Access error blocks command launch
// - Write one clears access error
// - Protected program or erase sets violation flag
// - Write one clears protection violation
// - Violation blocks launch and new sequence
// - Busy flag reads one while command runs
// - Completion status shows command or reset errors
// - Status bit two reserved, reads zero
// - Busy and status bits are read only
// - Reset fault may alter status reset value
// - Done enable gates command complete interrupt
// - Double fault flag set, write one clears
// - Single fault flag set unless ignoring
package fser_pkg;
    // Register word indices, byte address is four times the index
    localparam logic [7:0] FSER_IDX_CFG     = 8'h04;  // Command config (done enable, ignore)
    localparam logic [7:0] FSER_IDX_ERRCFG  = 8'h05;
    localparam logic [7:0] FSER_IDX_STATUS  = 8'h06;
    localparam logic [7:0] FSER_IDX_ERRSTAT = 8'h07;
    localparam logic [7:0] FSER_IDX_IRQSTAT = 8'h10;  // Sticky event status
    localparam logic [7:0] FSER_IDX_IRQMASK = 8'h11;  // Event mask
    localparam int         FSER_ADDR_W      = 8;
    // Field positions
    localparam int FSER_B_DONE_IE   = 7;
    localparam int FSER_B_IGN_SF    = 4;
    localparam int FSER_B_DF_IE     = 1;
    localparam int FSER_B_SF_IE     = 0;
    localparam int FSER_B_DONE      = 7;
    localparam int FSER_B_ACCESS_ERROR_FLAG    = 5;
    localparam int FSER_B_PVIOL     = 4;
    localparam int FSER_B_BUSY      = 3;
    localparam int FSER_B_DF        = 1;
    localparam int FSER_B_SF        = 0;
    // Sticky event bits: 0 single, 1 double, 2 done, 3 access err, 4 violation
    localparam int FSER_NEV         = 5;
    // Reset values
    localparam logic [7:0] FSER_RST_CFG    = 8'h00;
    localparam logic [7:0] FSER_RST_ERRCFG = 8'h00;
    localparam logic [1:0] FSER_RST_MGST   = 2'h0;
    localparam logic [FSER_NEV-1:0] FSER_RST_EV = 5'h00;
    // Bus responses
    localparam logic [1:0] FSER_RESP_OK    = 2'h0;
    localparam logic [1:0] FSER_RESP_SLV   = 2'h2;
    // Command engine states
    typedef enum logic [0:0] {FSER_IDLE, FSER_RUN} fser_state_t;
endpackage : fser_pkg

/* hw/fser_regs.sv */
// Flash status and error interrupt register bank with AXI4-Lite slave
`timescale 1ns/1ns
module fser_regs
    import fser_pkg::*;
(
    input  wire logic                    clk,            // 10 MHz clock
    input  wire logic                    rst_n,          // Sync reset, active low
    input  wire logic [31:0]             s_awaddr,       // Write address
    input  wire logic                    s_awvalid,      // Write address valid
    output logic                         s_awready,      // Write address ready
    input  wire logic [31:0]             s_wdata,        // Write data
    input  wire logic [3:0]              s_wstrb,        // Byte strobes
    input  wire logic                    s_wvalid,       // Write data valid
    output logic                         s_wready,       // Write data ready
    output logic [1:0]                   s_bresp,        // Write response
    output logic                         s_bvalid,       // Write response valid
    input  wire logic                    s_bready,       // Write response ready
    input  wire logic [31:0]             s_araddr,       // Read address
    input  wire logic                    s_arvalid,      // Read address valid
    output logic                         s_arready,      // Read address ready
    output logic [31:0]                  s_rdata,        // Read data
    output logic [1:0]                   s_rresp,        // Read response
    output logic                         s_rvalid,       // Read data valid
    input  wire logic                    s_rready,       // Read data ready
    input  wire logic                    cmd_complete,   // Controller finished command
    input  wire logic                    seq_violation,  // Sequence or illegal command
    input  wire logic                    prot_violation, // Protected program/erase try
    input  wire logic                    seq_start,      // Controller wants new sequence
    input  wire logic                    double_fault,   // Double-bit fault / invalid read
    input  wire logic                    single_fault,   // Single-bit fault detected
    input  wire logic [1:0]              cmd_err_status, // Completion status from controller
    input  wire logic                    cmd_err_valid,  // Completion status update strobe
    input  wire logic                    reset_seq_df,   // Double fault in reset sequence
    output logic                         cmd_launch,     // One-cycle command launch pulse
    output logic                         seq_allow,      // New sequence may start
    output logic                         ignore_single_fault, // Single fault ignoring
    output logic                         irq             // Level interrupt
);
    import fser_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus channel state
    logic                   aw_have_reg, aw_have_next;
    logic                   w_have_reg,  w_have_next;
    logic [FSER_ADDR_W-1:0] waddr_reg,   waddr_next;
    logic [7:0]             wdat_reg,    wdat_next;
    logic                   wstb_reg,    wstb_next;
    logic                   bvalid_reg,  bvalid_next;
    logic [1:0]             bresp_reg,   bresp_next;
    logic                   rvalid_reg,  rvalid_next;
    logic [1:0]             rresp_reg,   rresp_next;
    logic [31:0]            rdata_reg,   rdata_next;
    logic [2:0]             rdy_reg,     rdy_next;   // Registered ready: ar, w, aw
    logic                   do_write;
    logic [FSER_ADDR_W-1:0] widx, ridx;

    // Block state
    logic [7:0]          cfg_reg,     cfg_next;
    logic [7:0]          errcfg_reg,  errcfg_next;
    logic                done_reg,    done_next;
    logic                access_error_flag_reg,  access_error_flag_next;
    logic                pviol_reg,   pviol_next;
    logic [1:0]          mgst_reg,    mgst_next;
    logic                df_reg,      df_next;
    logic                sf_reg,      sf_next;
    logic [FSER_NEV-1:0] ev_reg,      ev_next;
    logic [FSER_NEV-1:0] mask_reg,    mask_next;
    logic                launch_reg,  launch_next;
    logic                allow_reg,   allow_next;
    logic                irq_reg,     irq_next;
    logic                rst_seen_reg, rst_seen_next;
    fser_state_t         state_reg,   state_next;
    logic [7:0]          status_rd, errstat_rd;
    logic                wr_cfg, wr_errcfg, wr_stat, wr_errstat, wr_evclr, wr_mask;
    logic [FSER_NEV-1:0] ev_set;

    ////////////////////////////////////////////////////////////////////////
    // Write path: address and data taken in either order, one write at a time
    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        waddr_next   = waddr_reg;
        wdat_next    = wdat_reg;
        wstb_next    = wstb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        do_write     = 1'b0;
        if (s_awvalid && !aw_have_reg && !bvalid_reg) begin
            aw_have_next = 1'b1;
            waddr_next   = s_awaddr[FSER_ADDR_W+1:2];
        end
        if (s_wvalid && !w_have_reg && !bvalid_reg) begin
            w_have_next = 1'b1;
            wdat_next   = s_wdata[7:0];
            wstb_next   = s_wstrb[0];
        end
        if (aw_have_reg && w_have_reg) begin
            do_write     = wstb_reg;
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = (s_awaddr_known(waddr_reg)) ? FSER_RESP_OK : FSER_RESP_SLV;
        end
        if (bvalid_reg && s_bready) begin
            bvalid_next = 1'b0;
        end
    end

    // Decoded register for mapped addresses
    function automatic logic s_awaddr_known(input logic [FSER_ADDR_W-1:0] a);
        s_awaddr_known = (a == FSER_IDX_CFG) || (a == FSER_IDX_ERRCFG) ||
                         (a == FSER_IDX_STATUS) || (a == FSER_IDX_ERRSTAT) ||
                         (a == FSER_IDX_IRQSTAT) || (a == FSER_IDX_IRQMASK);
    endfunction : s_awaddr_known

    // Write strobes per register
    always_comb begin
        widx       = waddr_reg;
        wr_cfg     = do_write && (widx == FSER_IDX_CFG);
        wr_errcfg  = do_write && (widx == FSER_IDX_ERRCFG);
        wr_stat    = do_write && (widx == FSER_IDX_STATUS);
        wr_errstat = do_write && (widx == FSER_IDX_ERRSTAT);
        wr_evclr   = do_write && (widx == FSER_IDX_IRQSTAT);
        wr_mask    = do_write && (widx == FSER_IDX_IRQMASK);
    end

    ////////////////////////////////////////////////////////////////////////
    // Readback images
    always_comb begin
        status_rd = 8'h00;                               // Bit 2 and spares read 0
        status_rd[FSER_B_DONE]   = done_reg;
        status_rd[FSER_B_ACCESS_ERROR_FLAG] = access_error_flag_reg;
        status_rd[FSER_B_PVIOL]  = pviol_reg;
        status_rd[FSER_B_BUSY]   = (state_reg == FSER_RUN);
        status_rd[1:0]           = mgst_reg;
        errstat_rd = 8'h00;
        errstat_rd[FSER_B_DF] = df_reg;
        errstat_rd[FSER_B_SF] = sf_reg;
    end

    // Read path: one read at a time, answer one cycle after address taken
    always_comb begin
        rvalid_next = rvalid_reg;
        rresp_next  = rresp_reg;
        rdata_next  = rdata_reg;
        ridx        = s_araddr[FSER_ADDR_W+1:2];
        if (rvalid_reg && s_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = FSER_RESP_OK;
            rdata_next  = 32'h0000_0000;
            unique case (ridx)
                FSER_IDX_CFG:     rdata_next[7:0] = cfg_reg;
                FSER_IDX_ERRCFG:  rdata_next[7:0] = errcfg_reg;
                FSER_IDX_STATUS:  rdata_next[7:0] = status_rd;
                FSER_IDX_ERRSTAT: rdata_next[7:0] = errstat_rd;
                FSER_IDX_IRQSTAT: rdata_next[FSER_NEV-1:0] = ev_reg;
                FSER_IDX_IRQMASK: rdata_next[FSER_NEV-1:0] = mask_reg;
                default:          rresp_next = FSER_RESP_SLV;
            endcase
        end
        // Ready flags follow next-state so the outputs come from flops
        rdy_next = {!rvalid_next, !w_have_next && !bvalid_next,
                    !aw_have_next && !bvalid_next};
    end

    ////////////////////////////////////////////////////////////////////////
    // Command engine and status flags; hardware sets win over clears
    always_comb begin
        cfg_next      = cfg_reg;
        errcfg_next   = errcfg_reg;
        done_next     = done_reg;
        access_error_flag_next   = access_error_flag_reg;
        pviol_next    = pviol_reg;
        mgst_next     = mgst_reg;
        df_next       = df_reg;
        sf_next       = sf_reg;
        state_next    = state_reg;
        launch_next   = 1'b0;
        rst_seen_next = 1'b1;
        if (wr_cfg) begin
            cfg_next = wdat_reg & 8'h90;                 // Done enable, ignore single
        end
        if (wr_errcfg) begin
            errcfg_next = wdat_reg & 8'h03;
        end
        // Write one clears error flags, write zero leaves them
        if (wr_stat && wdat_reg[FSER_B_ACCESS_ERROR_FLAG]) begin
            access_error_flag_next = 1'b0;
        end
        if (wr_stat && wdat_reg[FSER_B_PVIOL]) begin
            pviol_next = 1'b0;
        end
        // Launch only when idle-done and no error pending
        if (wr_stat && wdat_reg[FSER_B_DONE] && done_reg && !access_error_flag_reg && !pviol_reg) begin
            done_next   = 1'b0;
            launch_next = 1'b1;
            state_next  = FSER_RUN;
            mgst_next   = FSER_RST_MGST;
        end
        if (state_reg == FSER_RUN && (cmd_complete || seq_violation || prot_violation)) begin
            done_next  = 1'b1;
            state_next = FSER_IDLE;
        end
        if (cmd_err_valid) begin
            mgst_next = cmd_err_status;
        end
        if (seq_violation) begin
            access_error_flag_next = 1'b1;
        end
        if (prot_violation) begin
            pviol_next = 1'b1;
        end
        if (wr_errstat && wdat_reg[FSER_B_DF]) begin
            df_next = 1'b0;
        end
        if (wr_errstat && wdat_reg[FSER_B_SF]) begin
            sf_next = 1'b0;
        end
        if (double_fault) begin
            df_next = 1'b1;
        end
        if (single_fault && !cfg_reg[FSER_B_IGN_SF]) begin
            sf_next = 1'b1;
        end
        // Fault in the reset sequence alters the post-reset status
        if (!rst_seen_reg && reset_seq_df) begin
            mgst_next = 2'h3;
        end
    end

    // Sequence permission and interrupt line
    always_comb begin
        allow_next = !pviol_next;
        ev_set     = {pviol_reg == 1'b0 && pviol_next, access_error_flag_reg == 1'b0 && access_error_flag_next,
                      done_reg == 1'b0 && done_next, df_reg == 1'b0 && df_next,
                      sf_reg == 1'b0 && sf_next};
        ev_next    = ev_reg;
        mask_next  = mask_reg;
        if (wr_evclr) begin
            ev_next = ev_reg & ~wdat_reg[FSER_NEV-1:0];
        end
        ev_next = ev_next | ev_set;
        if (wr_mask) begin
            mask_next = wdat_reg[FSER_NEV-1:0];
        end
        // Level request from flag and enable, plus masked sticky events
        irq_next = (df_next && errcfg_next[FSER_B_DF_IE])
                 | (sf_next && errcfg_next[FSER_B_SF_IE])
                 | (done_next && cfg_next[FSER_B_DONE_IE])
                 | (|(ev_next & mask_next));
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            waddr_reg    <= '0;
            wdat_reg     <= 8'h00;
            wstb_reg     <= 1'b0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= FSER_RESP_OK;
            rvalid_reg   <= 1'b0;
            rresp_reg    <= FSER_RESP_OK;
            rdata_reg    <= 32'h0000_0000;
            rdy_reg      <= 3'h7;
            cfg_reg      <= FSER_RST_CFG;
            errcfg_reg   <= FSER_RST_ERRCFG;
            done_reg     <= 1'b1;
            access_error_flag_reg   <= 1'b0;
            pviol_reg    <= 1'b0;
            mgst_reg     <= FSER_RST_MGST;
            df_reg       <= 1'b0;
            sf_reg       <= 1'b0;
            ev_reg       <= FSER_RST_EV;
            mask_reg     <= FSER_RST_EV;
            launch_reg   <= 1'b0;
            allow_reg    <= 1'b0;
            irq_reg      <= 1'b0;
            rst_seen_reg <= 1'b0;
            state_reg    <= FSER_IDLE;
        end else begin
            aw_have_reg  <= aw_have_next;
            w_have_reg   <= w_have_next;
            waddr_reg    <= waddr_next;
            wdat_reg     <= wdat_next;
            wstb_reg     <= wstb_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            rvalid_reg   <= rvalid_next;
            rresp_reg    <= rresp_next;
            rdata_reg    <= rdata_next;
            rdy_reg      <= rdy_next;
            cfg_reg      <= cfg_next;
            errcfg_reg   <= errcfg_next;
            done_reg     <= done_next;
            access_error_flag_reg   <= access_error_flag_next;
            pviol_reg    <= pviol_next;
            mgst_reg     <= mgst_next;
            df_reg       <= df_next;
            sf_reg       <= sf_next;
            ev_reg       <= ev_next;
            mask_reg     <= mask_next;
            launch_reg   <= launch_next;
            allow_reg    <= allow_next;
            irq_reg      <= irq_next;
            rst_seen_reg <= rst_seen_next;
            state_reg    <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign s_awready           = rdy_reg[0];
    assign s_wready            = rdy_reg[1];
    assign s_bvalid            = bvalid_reg;
    assign s_bresp             = bresp_reg;
    assign s_arready           = rdy_reg[2];
    assign s_rvalid            = rvalid_reg;
    assign s_rresp             = rresp_reg;
    assign s_rdata             = rdata_reg;
    assign cmd_launch          = launch_reg;
    assign seq_allow           = allow_reg;
    assign ignore_single_fault = cfg_reg[FSER_B_IGN_SF];
    assign irq                 = irq_reg;
endmodule : fser_regs
